// File: hdl/rlp_pkg.sv
package rlp_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] RLP_ADDR_ENABLES = 16'h3400;
    localparam logic [15:0] RLP_ADDR_DIVIDER = 16'h3402;
    localparam logic [15:0] RLP_ADDR_RED_TIMES = 16'h3404;
    localparam logic [15:0] RLP_ADDR_GREEN_TIMES = 16'h3406;
    localparam logic [15:0] RLP_ADDR_BLUE_TIMES = 16'h3408;
    localparam logic [15:0] RLP_ADDR_SLOPE = 16'h340A;
    localparam logic [15:0] RLP_ADDR_MAX_DUTY = 16'h340C;
    localparam logic [15:0] RLP_ADDR_WHITE = 16'h340E;
    localparam logic [15:0] RLP_ADDR_STATUS = 16'h3410;
    localparam logic [15:0] RLP_REG_RESET = 16'h0000;
    localparam logic [15:0] RLP_READ_UNMAPPED = 16'h0000;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int RLP_EN_WHITE_BIT = 8;
    localparam int RLP_EN_RED_BIT = 9;
    localparam int RLP_EN_GATE_BIT = 12;
    localparam int RLP_TIME_ON_LSB = 0;
    localparam int RLP_TIME_OFF_LSB = 8;
    localparam int RLP_WHITE_SEL_LSB = 8;

    // ------------------------------------------------------------
    // Timing counts
    // ------------------------------------------------------------
    // One duty period is 16 working clocks; full duty is 16
    localparam logic [3:0] RLP_POS_LAST = 4'hF;
    localparam logic [4:0] RLP_DUTY_FULL = 5'h10;
    // Pulse period is 128 step clocks
    localparam logic [6:0] RLP_STEP_ONE = 7'h01;
    // White: 64 steps per period, prescale 4 (64Hz) to 256 (1Hz)
    localparam logic [8:0] RLP_WHITE_PRE_BASE = 9'h004;
    localparam logic [2:0] RLP_WHITE_SEL_MAX = 3'h6;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RLP_PH_OFF = 2'b00,
        RLP_PH_RISE = 2'b01,
        RLP_PH_HOLD = 2'b11,
        RLP_PH_FALL = 2'b10
    } rlp_phase_t;

    typedef struct packed {
        rlp_phase_t phase;
        logic [4:0] duty;
        logic [7:0] slope_cnt;
    } rlp_chan_t;

    typedef struct packed {
        logic [15:0] enables;
        logic [15:0] divider;
        logic [15:0] slope;
        logic [15:0] max_duty;
        logic [15:0] white;
        logic [2:0][15:0] times;
        logic src_prev;
        logic [3:0] div_cnt;
        logic [3:0] pos;
        logic [6:0] step;
        rlp_chan_t [2:0] chan;
        logic [8:0] white_pre;
        logic [5:0] white_step;
        logic [15:0] rdata;
        logic [3:0] led;
    } rlp_state_t;

endpackage

// File: hdl/rlp_led_pwm.sv
`timescale 1ns/100ps
// How it works
// RQ1: All timing comes from the slow pwm_source_clock of roughly 16KHz.
// RQ2: Divider register divides source clock by 1 to 16 for working clock.
// RQ3: Duty period is 16 working clocks; high part follows duty value.
// RQ4: Step clock is working clock over 16; pulse period is 128 steps.
// RQ5: Non-zero slope ramps duty up from zero to maximum at on time.
// RQ6: Off time during ramp-up truncates ramp and starts ramping down.
// RQ7: Zero slope jumps straight to full duty at on, to off at off.
// RQ8: Ramp reaching maximum holds there until the off time arrives.
// RQ9: All colour channels share one 128-step period counter.
// RQ10: Per-channel on and off times place activity within shared period.
// RQ11: White channel has no ramp; fixed duty or fully off.
// RQ12: White runs straight from source clock; control sets period, duty.
// RQ13: White frequency 64Hz down to 1Hz, with 64 duty steps.
// RQ14: With all four enable bits zero the whole unit is stopped.
// RQ15: All colour enables clear resets colour counters and state.
// RQ16: Software should disable colour channels while changing settings.
// RQ17: After a live change, channels recover by next period boundary; code only corrects a stale phase within one period of steps.
// RQ18: External gate input, when enabled, gates every output stage.
// RQ19: Output high while duty-period position is below current duty.
module rlp_led_pwm
    import rlp_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic pwm_source_clock_in,
    input wire logic external_output_gate_in,
    output logic [15:0] reg_rdata_out,
    output logic led_red_out,
    output logic led_green_out,
    output logic led_blue_out,
    output logic led_white_out
);

    // ------------------------------------------------------------
    // State and tick decode
    // ------------------------------------------------------------
    rlp_state_t s;
    rlp_state_t next_s;
    logic src_tick;
    logic any_en;
    logic rgb_en;
    logic pwm_tick;
    logic step_tick;
    logic [4:0] duty_max;
    logic [2:0] white_sel;
    logic [8:0] white_lim;
    logic gate_open;

    // Next-state logic; settings are used live, no resampling
    always_comb begin
        next_s = s;
        src_tick = pwm_source_clock_in & ~s.src_prev; // see RQ1
        any_en = |s.enables[RLP_EN_GATE_BIT-1:RLP_EN_WHITE_BIT];
        rgb_en = |s.enables[RLP_EN_GATE_BIT-1:RLP_EN_RED_BIT];
        pwm_tick = 1'b0;
        step_tick = 1'b0;
        duty_max = (s.max_duty[4:0] > RLP_DUTY_FULL) ? RLP_DUTY_FULL
                                                       : s.max_duty[4:0];
        white_sel = s.white[RLP_WHITE_SEL_LSB +: 3];
        if (white_sel > RLP_WHITE_SEL_MAX) begin
            white_sel = RLP_WHITE_SEL_MAX;
        end
        white_lim = (RLP_WHITE_PRE_BASE << white_sel) - 9'h001; // see RQ13
        gate_open = ~s.enables[RLP_EN_GATE_BIT] | external_output_gate_in;
        next_s.src_prev = pwm_source_clock_in;

        // Working clock divider, ratio is field plus one
        if (src_tick && rgb_en) begin
            if (s.div_cnt == s.divider[3:0]) begin // see RQ2
                next_s.div_cnt = 4'h0;
                pwm_tick = 1'b1;
            end else begin
                next_s.div_cnt = s.div_cnt + 4'h1;
            end
        end

        // Duty position and shared step counter
        if (pwm_tick) begin
            next_s.pos = s.pos + 4'h1; // see RQ3
            step_tick = (s.pos == RLP_POS_LAST); // see RQ4
        end
        if (step_tick) begin
            next_s.step = s.step + RLP_STEP_ONE; // see RQ9
        end

        // Colour channels; on/off compared every step so a stale
        // phase is corrected within one period
        for (int i = 0; i < 3; i++) begin
            if (step_tick) begin
                next_s.chan[i].slope_cnt = s.chan[i].slope_cnt + 8'h01;
                if (s.chan[i].slope_cnt >= s.slope[7:0] - 8'h01) begin
                    next_s.chan[i].slope_cnt = 8'h00;
                end
            end
            case (s.chan[i].phase)
                RLP_PH_OFF: begin
                    next_s.chan[i].duty = 5'h00;
                    if (step_tick &&
                        s.step == s.times[i][RLP_TIME_ON_LSB +: 7]) begin
                        next_s.chan[i].slope_cnt = 8'h00;
                        if (s.slope[7:0] == 8'h00) begin
                            next_s.chan[i].phase = RLP_PH_HOLD; // see RQ7
                            next_s.chan[i].duty = duty_max;
                        end else begin
                            next_s.chan[i].phase = RLP_PH_RISE; // see RQ5
                        end
                    end
                end
                RLP_PH_RISE: begin
                    if (step_tick &&
                        s.step == s.times[i][RLP_TIME_OFF_LSB +: 7]) begin
                        next_s.chan[i].phase = RLP_PH_FALL; // see RQ6
                        next_s.chan[i].slope_cnt = 8'h00;
                    end else if (step_tick &&
                                 s.chan[i].slope_cnt >=
                                 s.slope[7:0] - 8'h01) begin
                        if (s.chan[i].duty + 5'h01 >= duty_max) begin
                            next_s.chan[i].phase = RLP_PH_HOLD; // see RQ8
                            next_s.chan[i].duty = duty_max;
                        end else begin
                            next_s.chan[i].duty = s.chan[i].duty + 5'h01;
                        end
                    end
                end
                RLP_PH_HOLD: begin
                    next_s.chan[i].duty = duty_max; // see RQ8
                    if (step_tick &&
                        s.step == s.times[i][RLP_TIME_OFF_LSB +: 7]) begin
                        next_s.chan[i].slope_cnt = 8'h00;
                        if (s.slope[7:0] == 8'h00) begin
                            next_s.chan[i].phase = RLP_PH_OFF; // see RQ7
                            next_s.chan[i].duty = 5'h00;
                        end else begin
                            next_s.chan[i].phase = RLP_PH_FALL;
                        end
                    end
                end
                RLP_PH_FALL: begin
                    if (s.slope[7:0] == 8'h00) begin // see RQ17
                        next_s.chan[i].phase = RLP_PH_OFF;
                        next_s.chan[i].duty = 5'h00;
                    end else if (step_tick &&
                                 s.chan[i].slope_cnt >=
                                 s.slope[7:0] - 8'h01) begin
                        if (s.chan[i].duty <= 5'h01) begin
                            next_s.chan[i].phase = RLP_PH_OFF;
                            next_s.chan[i].duty = 5'h00;
                        end else begin
                            next_s.chan[i].duty = s.chan[i].duty - 5'h01;
                        end
                    end
                end
                default: begin
                    next_s.chan[i].phase = RLP_PH_OFF;
                    next_s.chan[i].duty = 5'h00;
                end
            endcase
            // On/off times set each channel within the shared period
            next_s.led[i] = s.enables[RLP_EN_RED_BIT + i] & gate_open &
                ({1'b0, s.pos} < s.chan[i].duty); // see RQ10, RQ18, RQ19
        end

        // Colour reset when every colour enable is clear
        if (!rgb_en) begin
            next_s.div_cnt = 4'h0; // see RQ15
            next_s.pos = 4'h0;
            next_s.step = 7'h00;
            for (int i = 0; i < 3; i++) begin
                next_s.chan[i] = '0;
            end
        end

        // White channel straight off source clock, no ramp logic
        if (!s.enables[RLP_EN_WHITE_BIT]) begin
            next_s.white_pre = 9'h000; // see RQ11
            next_s.white_step = 6'h00;
        end else if (src_tick) begin
            if (s.white_pre >= white_lim) begin // see RQ12
                next_s.white_pre = 9'h000;
                next_s.white_step = s.white_step + 6'h01;
            end else begin
                next_s.white_pre = s.white_pre + 9'h001;
            end
        end
        next_s.led[3] = s.enables[RLP_EN_WHITE_BIT] & gate_open &
            (s.white_step < s.white[5:0]); // see RQ13, RQ18

        // Whole unit stopped: nothing may toggle an output
        if (!any_en) begin
            next_s.led = 4'h0; // see RQ14
        end

        // Register writes; RQ16 leaves live changes to software care
        if (reg_wr_in) begin
            case (reg_addr_in)
                RLP_ADDR_ENABLES: next_s.enables = reg_wdata_in;
                RLP_ADDR_DIVIDER: next_s.divider = reg_wdata_in;
                RLP_ADDR_RED_TIMES: next_s.times[0] = reg_wdata_in;
                RLP_ADDR_GREEN_TIMES: next_s.times[1] = reg_wdata_in;
                RLP_ADDR_BLUE_TIMES: next_s.times[2] = reg_wdata_in;
                RLP_ADDR_SLOPE: next_s.slope = reg_wdata_in;
                RLP_ADDR_MAX_DUTY: next_s.max_duty = reg_wdata_in;
                RLP_ADDR_WHITE: next_s.white = reg_wdata_in;
                default: next_s.enables = s.enables;
            endcase
        end

        // Read data registered, held until the next read
        if (reg_rd_in) begin
            case (reg_addr_in)
                RLP_ADDR_ENABLES: next_s.rdata = s.enables;
                RLP_ADDR_DIVIDER: next_s.rdata = s.divider;
                RLP_ADDR_RED_TIMES: next_s.rdata = s.times[0];
                RLP_ADDR_GREEN_TIMES: next_s.rdata = s.times[1];
                RLP_ADDR_BLUE_TIMES: next_s.rdata = s.times[2];
                RLP_ADDR_SLOPE: next_s.rdata = s.slope;
                RLP_ADDR_MAX_DUTY: next_s.rdata = s.max_duty;
                RLP_ADDR_WHITE: next_s.rdata = s.white;
                RLP_ADDR_STATUS: next_s.rdata = {1'b0, s.step, s.pos, s.led};
                default: next_s.rdata = RLP_READ_UNMAPPED;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from state flops
    assign reg_rdata_out = s.rdata;
    assign led_red_out = s.led[0];
    assign led_green_out = s.led[1];
    assign led_blue_out = s.led[2];
    assign led_white_out = s.led[3];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Channel checks watch red; green and blue share the same logic
    AST_DIV_RESTART: assert property ( // see RQ2
        @(posedge clock_in) disable iff (rst_in)
        pwm_tick |=> s.div_cnt == 4'h0)
        else $error("divider did not restart after working tick");

    AST_DIV_HOLD: assert property ( // see RQ1
        @(posedge clock_in) disable iff (rst_in)
        !src_tick |=> s.div_cnt == $past(s.div_cnt) || s.div_cnt == 4'h0)
        else $error("divider moved without a source tick");

    AST_POS_ADVANCE: assert property ( // see RQ3
        @(posedge clock_in) disable iff (rst_in)
        pwm_tick && rgb_en |=> s.pos == $past(s.pos) + 4'h1)
        else $error("duty position did not advance");

    AST_STEP_ADVANCE: assert property ( // see RQ4
        @(posedge clock_in) disable iff (rst_in)
        step_tick && rgb_en |=> s.step == $past(s.step) + 7'h01)
        else $error("step counter did not advance on step tick");

    AST_STEP_HOLD: assert property ( // see RQ4
        @(posedge clock_in) disable iff (rst_in)
        rgb_en && !step_tick |=> s.step == $past(s.step))
        else $error("step counter moved without a step tick");

    AST_DUTY_CAP: assert property ( // see RQ3
        @(posedge clock_in) disable iff (rst_in)
        s.chan[0].duty <= RLP_DUTY_FULL)
        else $error("duty beyond one full duty period");

    AST_RISE_START: assert property ( // see RQ5
        @(posedge clock_in) disable iff (rst_in)
        rgb_en && step_tick && s.slope[7:0] != 8'h00 &&
        s.chan[0].phase == RLP_PH_OFF && s.step == s.times[0][6:0]
        |=> s.chan[0].phase == RLP_PH_RISE && s.chan[0].duty == 5'h00)
        else $error("ramp did not start from zero at on time");

    AST_ZERO_SLOPE_JUMP: assert property ( // see RQ7
        @(posedge clock_in) disable iff (rst_in)
        rgb_en && step_tick && s.slope[7:0] == 8'h00 &&
        s.chan[0].phase == RLP_PH_OFF && s.step == s.times[0][6:0]
        |=> s.chan[0].phase == RLP_PH_HOLD &&
        s.chan[0].duty == $past(duty_max))
        else $error("zero slope did not jump to full duty");

    AST_TRUNCATE: assert property ( // see RQ6
        @(posedge clock_in) disable iff (rst_in)
        rgb_en && step_tick && s.chan[0].phase == RLP_PH_RISE &&
        s.step == s.times[0][14:8] |=> s.chan[0].phase == RLP_PH_FALL)
        else $error("ramp not truncated at off time");

    AST_HOLD_AT_MAX: assert property ( // see RQ8
        @(posedge clock_in) disable iff (rst_in)
        s.chan[0].phase == RLP_PH_HOLD &&
        !(reg_wr_in && reg_addr_in == RLP_ADDR_MAX_DUTY)
        |=> s.chan[0].phase != RLP_PH_HOLD || s.chan[0].duty == duty_max)
        else $error("hold phase left maximum duty");

    AST_RECOVER: assert property ( // see RQ17
        @(posedge clock_in) disable iff (rst_in)
        s.slope[7:0] == 8'h00 && s.chan[0].phase == RLP_PH_FALL
        |=> s.chan[0].phase == RLP_PH_OFF)
        else $error("stale fall phase kept after slope cleared");

    AST_OUT_DUTY: assert property ( // see RQ19
        @(posedge clock_in) disable iff (rst_in)
        s.enables[RLP_EN_RED_BIT] && gate_open
        |=> s.led[0] == ({1'b0, $past(s.pos)} < $past(s.chan[0].duty)))
        else $error("red output does not follow position and duty");

    AST_COLOUR_RESET: assert property ( // see RQ15
        @(posedge clock_in) disable iff (rst_in)
        !rgb_en |=> s.step == 7'h00 && s.pos == 4'h0 &&
        s.chan[0].phase == RLP_PH_OFF)
        else $error("colour counters not reset when disabled");

    AST_UNIT_OFF: assert property ( // see RQ14
        @(posedge clock_in) disable iff (rst_in)
        !any_en |=> s.led == 4'h0)
        else $error("output active while unit stopped");

    AST_GATE_CLOSED: assert property ( // see RQ18
        @(posedge clock_in) disable iff (rst_in)
        s.enables[RLP_EN_GATE_BIT] && !external_output_gate_in
        |=> s.led == 4'h0)
        else $error("output active while external gate closed");

    AST_WHITE_ZERO: assert property ( // see RQ11
        @(posedge clock_in) disable iff (rst_in)
        s.white[5:0] == 6'h00 |=> !s.led[3])
        else $error("white output active at zero duty");

    AST_WHITE_OFF: assert property ( // see RQ11
        @(posedge clock_in) disable iff (rst_in)
        !s.enables[RLP_EN_WHITE_BIT] |=> !s.led[3] && s.white_step == 6'h00)
        else $error("white channel active while disabled");

    AST_WHITE_HOLD: assert property ( // see RQ12
        @(posedge clock_in) disable iff (rst_in)
        s.enables[RLP_EN_WHITE_BIT] && !src_tick
        |=> s.white_step == $past(s.white_step))
        else $error("white step moved without a source tick");

    AST_WHITE_DUTY: assert property ( // see RQ13
        @(posedge clock_in) disable iff (rst_in)
        s.enables[RLP_EN_WHITE_BIT] && gate_open &&
        s.white_step < s.white[5:0] |=> s.led[3])
        else $error("white output low inside its duty");

endmodule

// File: bench/rlp_led_load.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// LED driver load and gate source
// ------------------------------------------------------------
module rlp_led_load (
    input wire logic clock_in,
    input wire logic clear_in,
    input wire logic gate_level_in,
    input wire logic [3:0] led_in,
    output logic pwm_source_clock_out,
    output logic external_output_gate_out,
    output logic [3:0][15:0] high_cnt_out,
    output logic [3:0][15:0] rise_cnt_out
);
    logic [2:0] src_cnt = 3'h0;
    logic [3:0] led_prev = 4'h0;
    logic [3:0] rises;

    // Eight clocks per source period: far above the real rate,
    // traded for a pulse period that fits in a short run
    always @(negedge clock_in) begin
        src_cnt <= src_cnt + 3'h1;
    end
    assign pwm_source_clock_out = src_cnt[2];

    // Gate level is chosen by the bench
    assign external_output_gate_out = gate_level_in;
    assign rises = led_in & ~led_prev;

    // High cycles and rising edges seen by each driver
    always @(posedge clock_in) begin
        led_prev <= led_in;
        for (int i = 0; i < 4; i++) begin
            if (clear_in) begin
                high_cnt_out[i] <= 16'h0000;
                rise_cnt_out[i] <= 16'h0000;
            end else begin
                high_cnt_out[i] <= high_cnt_out[i] + 16'(led_in[i]);
                rise_cnt_out[i] <= rise_cnt_out[i] + 16'(rises[i]);
            end
        end
    end
endmodule

// File: bench/tb_top.sv
`timescale 1ns/100ps
module tb_top
    import rlp_pkg::*;
;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic wr = 1'b0;
    logic rd_en = 1'b0;
    logic [15:0] wdata = 16'h0000;
    logic gate_level = 1'b1;
    logic clear = 1'b1;
    logic src_clk;
    logic gate;
    logic [15:0] rdata;
    logic [3:0] leds;
    logic [3:0][15:0] hi;
    logic [3:0][15:0] rise;
    logic [15:0] st;
    int err_total = 0;
    int compares = 0;
    logic [15:0] patt [8] = '{16'h1500, 16'h0009, 16'h3A05, 16'h0B7F,
        16'h6A15, 16'h00C3, 16'h000B, 16'h0529};

    // 50 MHz clock
    always #10 clock_in = ~clock_in;

    rlp_led_pwm uut (
        .clock_in(clock_in), .rst_in(rst_in), .reg_addr_in(addr),
        .reg_wr_in(wr), .reg_rd_in(rd_en), .reg_wdata_in(wdata),
        .pwm_source_clock_in(src_clk), .external_output_gate_in(gate),
        .reg_rdata_out(rdata), .led_red_out(leds[0]),
        .led_green_out(leds[1]), .led_blue_out(leds[2]),
        .led_white_out(leds[3])
    );

    rlp_led_load load (
        .clock_in(clock_in), .clear_in(clear), .gate_level_in(gate_level),
        .led_in(leds), .pwm_source_clock_out(src_clk),
        .external_output_gate_out(gate), .high_cnt_out(hi),
        .rise_cnt_out(rise)
    );

    // ------------------------------------------------------------
    // Access and measuring tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
        @(negedge clock_in);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clock_in);
        wr = 1'b0;
    endtask

    // Read data is registered, so it is taken a cycle later
    task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
        @(negedge clock_in);
        addr = a;
        rd_en = 1'b1;
        @(negedge clock_in);
        rd_en = 1'b0;
        @(negedge clock_in);
        d = rdata;
    endtask

    // Poll the step field; bounded so a stuck counter still ends
    task automatic wait_step(input logic [6:0] s);
        int n = 0;
        do begin
            rd_reg(RLP_ADDR_STATUS, st);
            n++;
        end while (st[14:8] !== s && n < 20000);
        if (st[14:8] !== s) begin
            check({9'h000, st[14:8]}, {9'h000, s});
        end
    endtask

    // Window must span whole periods for exact counts
    task automatic measure(input int cycles);
        @(negedge clock_in);
        clear = 1'b1;
        @(negedge clock_in);
        clear = 1'b0;
        repeat (cycles) @(negedge clock_in);
    endtask

    task automatic probe(input logic [6:0] s, input int cycles);
        wait_step(s);
        measure(cycles);
    endtask

    // Colour channels are stopped while settings change
    task automatic setup(input logic [15:0] dv, sl, mx, t0, t1, t2, en);
        wr_reg(RLP_ADDR_ENABLES, 16'h0000);
        wr_reg(RLP_ADDR_DIVIDER, dv);
        wr_reg(RLP_ADDR_SLOPE, sl);
        wr_reg(RLP_ADDR_MAX_DUTY, mx);
        wr_reg(RLP_ADDR_RED_TIMES, t0);
        wr_reg(RLP_ADDR_GREEN_TIMES, t1);
        wr_reg(RLP_ADDR_BLUE_TIMES, t2);
        wr_reg(RLP_ADDR_ENABLES, en);
    endtask

    function automatic logic [15:0] tm(input logic [6:0] on, off);
        return {1'b0, off, 1'b0, on};
    endfunction

    task automatic results();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(negedge clock_in);
        rst_in = 1'b0;
        for (int i = 0; i < 9; i++) begin
            rd_reg(RLP_ADDR_ENABLES + 16'(2 * i), st);
            check(st, RLP_REG_RESET);
        end
        for (int i = 0; i < 8; i++) begin
            wr_reg(RLP_ADDR_ENABLES + 16'(2 * i), patt[i]);
            rd_reg(RLP_ADDR_ENABLES + 16'(2 * i), st);
            check(st, patt[i]);
            wr_reg(RLP_ADDR_ENABLES + 16'(2 * i), 16'h0000);
        end
        wr_reg(RLP_ADDR_STATUS, 16'hFFFF);
        wr_reg(16'h3412, 16'hFFFF);
        rd_reg(RLP_ADDR_STATUS, st);
        check(st, 16'h0000);
        rd_reg(16'h3412, st);
        check(st, RLP_READ_UNMAPPED);
        $display("test registers done");
        setup(16'h0000, 16'h0000, 16'h0008, tm(7'h02, 7'h05), 16'h0000,
            16'h0000, 16'h0200);
        probe(7'h03, 128);
        check(hi[0], 16'h0040);
        probe(7'h06, 128);
        check(hi[0], 16'h0000);
        $display("test zero slope done");
        for (int r = 2; r <= 16; r += 14) begin
            setup(16'(r - 1), 16'h0000, 16'h0008, tm(7'h01, 7'h7F),
                16'h0000, 16'h0000, 16'h0200);
            probe(7'h02, 4096);
            check(rise[0], 16'(4096 / (128 * r)));
            check(hi[0], 16'h0800);
        end
        $display("test divider done");
        setup(16'h0000, 16'h0001, 16'h0004, tm(7'h01, 7'h14), 16'h0000,
            16'h0000, 16'h0200);
        probe(7'h02, 128);
        check(16'(hi[0] > 0 && hi[0] < 32), 16'h0001);
        probe(7'h0C, 128);
        check(hi[0], 16'h0020);
        setup(16'h0000, 16'h0002, 16'h0010, tm(7'h01, 7'h06), 16'h0000,
            16'h0000, 16'h0200);
        probe(7'h07, 128);
        check(hi[0], 16'h0010);
        // Live slope change mid-fall must drop the channel at once
        wr_reg(RLP_ADDR_SLOPE, 16'h0000);
        measure(128);
        check(hi[0], 16'h0000);
        probe(7'h0E, 128);
        check(hi[0], 16'h0000);
        $display("test ramp done");
        setup(16'h0000, 16'h0000, 16'h001F, tm(7'h01, 7'h04),
            tm(7'h04, 7'h07), tm(7'h07, 7'h0A), 16'h0E00);
        for (int i = 0; i < 3; i++) begin
            probe(7'(2 + 3 * i), 128);
            for (int j = 0; j < 3; j++) begin
                check(hi[j], (i == j) ? 16'h0080 : 16'h0000);
            end
        end
        wr_reg(RLP_ADDR_ENABLES, 16'h0800);
        rd_reg(RLP_ADDR_STATUS, st);
        check(16'(st[14:8] >= 7'h08), 16'h0001);
        wr_reg(RLP_ADDR_ENABLES, 16'h0000);
        measure(256);
        check(16'(|hi), 16'h0000);
        rd_reg(RLP_ADDR_STATUS, st);
        check(st, 16'h0000);
        $display("test channels done");
        setup(16'h0000, 16'h0000, 16'h0010, tm(7'h01, 7'h64), 16'h0000,
            16'h0000, 16'h1200);
        gate_level = 1'b0;
        probe(7'h02, 128);
        check(hi[0], 16'h0000);
        gate_level = 1'b1;
        measure(128);
        check(hi[0], 16'h0080);
        wr_reg(RLP_ADDR_ENABLES, 16'h0200);
        gate_level = 1'b0;
        measure(128);
        check(hi[0], 16'h0080);
        gate_level = 1'b1;
        $display("test gate done");
        // Divider at its largest must not slow the white channel
        wr_reg(RLP_ADDR_DIVIDER, 16'h000F);
        for (int s = 0; s < 2; s++) begin
            wr_reg(RLP_ADDR_WHITE, {5'h00, 3'(s), 8'h20});
            wr_reg(RLP_ADDR_ENABLES, 16'h0100);
            repeat (4096) @(negedge clock_in);
            measure(4096);
            check(rise[3], 16'(2 >> s));
            check(hi[3], 16'h0800);
        end
        wr_reg(RLP_ADDR_WHITE, 16'h0000);
        repeat (4096) @(negedge clock_in);
        measure(1024);
        check(hi[3], 16'h0000);
        $display("test white done");
        results();
    end

    // Run needs about 41000 cycles; cut off at 100000
    initial begin
        #2000000;
        err_total++;
        $display("watchdog expired at t=%0t", $time);
        results();
    end
endmodule
